// [common/bpcc_pkg.sv]
// Constants and types shared by the bridge port command block
package bpcc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] BPCC_PORT_COMMAND_OFS = 12'h004;
    localparam logic [15:0] BPCC_PORT_COMMAND_RST = 16'h0000;
    localparam logic [15:0] BPCC_PORT_COMMAND_WMASK = 16'h0547;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BPCC_IO_SPACE_ENABLE_BIT           = 0;
    localparam int BPCC_MEMORY_SPACE_ENABLE_BIT       = 1;
    localparam int BPCC_REQUEST_FORWARDING_ENABLE_BIT = 2;
    localparam int BPCC_SPECIAL_CYCLE_BIT             = 3;
    localparam int BPCC_WRITE_INVALIDATE_BIT          = 4;
    localparam int BPCC_PALETTE_SNOOP_BIT             = 5;
    localparam int BPCC_PARITY_ERROR_RESPONSE_BIT     = 6;
    localparam int BPCC_STEPPING_BIT                  = 7;
    localparam int BPCC_SYSTEM_ERROR_ENABLE_BIT       = 8;
    localparam int BPCC_FAST_BACK_TO_BACK_BIT         = 9;
    localparam int BPCC_LEGACY_INTERRUPT_DISABLE_BIT  = 10;

    // ------------------------------------------------------------
    // Traffic classes seen on the secondary side
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BPCC_REQ_MEM   = 3'h0,
        BPCC_REQ_IO    = 3'h1,
        BPCC_REQ_MSI   = 3'h2,
        BPCC_REQ_CPL   = 3'h3,
        BPCC_REQ_OTHER = 3'h4
    } bpcc_req_kind_t;

    typedef enum logic [1:0] {
        BPCC_MSG_COR      = 2'h0,
        BPCC_MSG_NONFATAL = 2'h1,
        BPCC_MSG_FATAL    = 2'h2,
        BPCC_MSG_OTHER    = 2'h3
    } bpcc_msg_kind_t;

endpackage : bpcc_pkg

// [common/bpcc_cmd_if.sv]
// Command bit bundle between the register and the gating logic
`timescale 1ns/1ps
interface bpcc_cmd_if;
    logic io_space_enable;
    logic memory_space_enable;
    logic request_forwarding_enable;
    logic parity_error_response;
    logic system_error_enable;
    logic legacy_interrupt_disable;

    modport reg_side (
        output io_space_enable,
        output memory_space_enable,
        output request_forwarding_enable,
        output parity_error_response,
        output system_error_enable,
        output legacy_interrupt_disable
    );

    modport use_side (
        input io_space_enable,
        input memory_space_enable,
        input request_forwarding_enable,
        input parity_error_response,
        input system_error_enable,
        input legacy_interrupt_disable
    );
endinterface : bpcc_cmd_if

// [verilog/bpcc_cmd_reg.sv]
// Port command register storage with byte-lane writes
`timescale 1ns/1ps
module bpcc_cmd_reg
    import bpcc_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_wr_hit,
    input  wire logic [1:0]  i_wr_be,
    input  wire logic [15:0] i_wr_data,
    output      logic [15:0] o_value,
    bpcc_cmd_if.reg_side     cmd
);

    logic [15:0] cmd_ff;
    logic [15:0] nxt_cmd;
    logic [15:0] lane_mask;

    // ------------------------------------------------------------
    // Byte lane enables
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            assign lane_mask[g*8 +: 8] = {8{i_wr_be[g]}};
        end
    endgenerate

    // Only writable bits take data; legacy and reserved stay zero
    always_comb begin
        nxt_cmd = cmd_ff;
        if (i_wr_hit) begin
            nxt_cmd = (cmd_ff & ~(lane_mask & BPCC_PORT_COMMAND_WMASK))
                    | (i_wr_data & lane_mask & BPCC_PORT_COMMAND_WMASK); // R13
        end
    end

    // Everything but the own interrupts starts disabled
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cmd_ff <= BPCC_PORT_COMMAND_RST; // R14
        end else begin
            cmd_ff <= nxt_cmd;
        end
    end

    assign o_value                       = cmd_ff;
    assign cmd.io_space_enable           = cmd_ff[BPCC_IO_SPACE_ENABLE_BIT];
    assign cmd.memory_space_enable       = cmd_ff[BPCC_MEMORY_SPACE_ENABLE_BIT];
    assign cmd.request_forwarding_enable = cmd_ff[BPCC_REQUEST_FORWARDING_ENABLE_BIT];
    assign cmd.parity_error_response     = cmd_ff[BPCC_PARITY_ERROR_RESPONSE_BIT];
    assign cmd.system_error_enable       = cmd_ff[BPCC_SYSTEM_ERROR_ENABLE_BIT];
    assign cmd.legacy_interrupt_disable  = cmd_ff[BPCC_LEGACY_INTERRUPT_DISABLE_BIT];

endmodule : bpcc_cmd_reg

// [verilog/bpcc_port_cmd.sv]
// Bridge port command register and the traffic gating it controls
//
// How it works
// R01: I/O window hits on the primary bus are claimed only while I/O enable is set.
// R02: Memory and prefetch window hits are claimed only while memory enable is set.
// R03: Memory, I/O and MSI requests from below are held back while forwarding is off.
// R04: Blocked non-posted requests from below get an Unsupported Request completion.
// R05: Completions and other request kinds pass whatever the forwarding bit says.
// R06: With parity response on, poisoned completion or write raises the status set.
// R07: With parity response off, the parity status set never fires.
// R08: Own non-fatal and fatal errors reported if system error or device control allow.
// R09: Non-fatal and fatal messages from below pass only with system error enable set.
// R10: Correctable error messages from below always pass.
// R11: Interrupt disable negates the port's own interrupt.
// R12: Interrupts forwarded from below are never touched by interrupt disable.
// R13: Legacy bits 3,4,5,7,9 and bits 15:11 are read-only zero.
// R14: Reset clears every writable command bit.
`timescale 1ns/1ps
module bpcc_port_cmd
    import bpcc_pkg::*;
(
    input  wire logic           i_core_clk,
    input  wire logic           i_rst,
    // Configuration access
    input  wire logic           i_cfg_wr,
    input  wire logic           i_cfg_rd,
    input  wire logic [11:0]    i_cfg_addr,
    input  wire logic [1:0]     i_cfg_be,
    input  wire logic [15:0]    i_cfg_wdata,
    output      logic [15:0]    o_cfg_rdata,
    output      logic           o_cfg_rvalid,
    output      logic           o_cfg_hit,
    // Primary side window hits
    input  wire logic           i_pri_io_hit,
    input  wire logic           i_pri_mem_hit,
    input  wire logic           i_pri_pref_hit,
    output      logic           o_pri_io_claim,
    output      logic           o_pri_mem_claim,
    // Secondary side requests
    input  wire logic           i_sec_req_valid,
    input  wire bpcc_req_kind_t i_sec_req_kind,
    input  wire logic           i_sec_req_np,
    output      logic           o_sec_req_fwd,
    output      logic           o_sec_ur_cpl,
    // Poison events
    input  wire logic           i_poison_cpl_rx,
    input  wire logic           i_poison_wr_gen,
    output      logic           o_mdped_set,
    // Own errors
    input  wire logic           i_own_err_nonfatal,
    input  wire logic           i_own_err_fatal,
    input  wire logic           i_devctl_nonfatal_en,
    input  wire logic           i_devctl_fatal_en,
    output      logic           o_rpt_nonfatal,
    output      logic           o_rpt_fatal,
    // Error messages from below
    input  wire logic           i_sec_msg_valid,
    input  wire bpcc_msg_kind_t i_sec_msg_kind,
    output      logic           o_msg_fwd,
    // Interrupts
    input  wire logic [3:0]     i_own_intx,
    input  wire logic [3:0]     i_fwd_intx,
    output      logic [3:0]     o_own_intx,
    output      logic [3:0]     o_resolved_intx
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Requests that the forwarding bit governs
    function automatic logic bpcc_gated_kind(input bpcc_req_kind_t k);
        bpcc_gated_kind = (k == BPCC_REQ_MEM) || (k == BPCC_REQ_IO) || (k == BPCC_REQ_MSI);
    endfunction : bpcc_gated_kind

    logic        reg_hit;
    logic [15:0] cmd_value;
    bpcc_cmd_if  cmd ();

    assign reg_hit = (i_cfg_addr == BPCC_PORT_COMMAND_OFS);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    bpcc_cmd_reg u_cmd_reg (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_wr_hit   (i_cfg_wr && reg_hit),
        .i_wr_be    (i_cfg_be),
        .i_wr_data  (i_cfg_wdata),
        .o_value    (cmd_value),
        .cmd        (cmd)
    );

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [15:0] rdata_ff;
    logic        rvalid_ff;
    logic        hit_ff;
    logic [15:0] nxt_rdata;
    logic        nxt_rvalid;
    logic        nxt_hit;

    // Unmapped offsets read as zero so software sees a defined value
    always_comb begin
        nxt_rvalid = i_cfg_rd;
        nxt_hit    = i_cfg_rd && reg_hit;
        nxt_rdata  = 16'h0000;
        if (i_cfg_rd && reg_hit) begin
            nxt_rdata = cmd_value & BPCC_PORT_COMMAND_WMASK; // R13
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rdata_ff  <= 16'h0000;
            rvalid_ff <= 1'b0;
            hit_ff    <= 1'b0;
        end else begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            hit_ff    <= nxt_hit;
        end
    end

    assign o_cfg_rdata  = rdata_ff;
    assign o_cfg_rvalid = rvalid_ff;
    assign o_cfg_hit    = hit_ff;

    // ------------------------------------------------------------
    // Primary side claims
    // ------------------------------------------------------------
    // Combinational so a claim decision fits inside the decode cycle
    assign o_pri_io_claim  = i_pri_io_hit && cmd.io_space_enable; // R01
    assign o_pri_mem_claim = (i_pri_mem_hit || i_pri_pref_hit)
                          && cmd.memory_space_enable; // R02

    // ------------------------------------------------------------
    // Secondary side request gating
    // ------------------------------------------------------------
    logic req_blocked;

    assign req_blocked   = bpcc_gated_kind(i_sec_req_kind) && !cmd.request_forwarding_enable;
    // Completions and other kinds always pass
    assign o_sec_req_fwd = i_sec_req_valid && !req_blocked; // R03 R05
    // A blocked posted request is dropped silently, no completion owed
    assign o_sec_ur_cpl  = i_sec_req_valid && req_blocked && i_sec_req_np; // R04

    // ------------------------------------------------------------
    // Error reporting and message forwarding
    // ------------------------------------------------------------
    logic mdped_ff;
    logic rpt_nf_ff;
    logic rpt_fa_ff;
    logic nxt_mdped;
    logic nxt_rpt_nf;
    logic nxt_rpt_fa;

    // Registered so status and message logic see clean one-cycle pulses
    always_comb begin
        nxt_mdped  = cmd.parity_error_response
                  && (i_poison_cpl_rx || i_poison_wr_gen); // R06 R07
        nxt_rpt_nf = i_own_err_nonfatal
                  && (cmd.system_error_enable || i_devctl_nonfatal_en); // R08
        nxt_rpt_fa = i_own_err_fatal
                  && (cmd.system_error_enable || i_devctl_fatal_en); // R08
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            mdped_ff  <= 1'b0;
            rpt_nf_ff <= 1'b0;
            rpt_fa_ff <= 1'b0;
        end else begin
            mdped_ff  <= nxt_mdped;
            rpt_nf_ff <= nxt_rpt_nf;
            rpt_fa_ff <= nxt_rpt_fa;
        end
    end

    assign o_mdped_set    = mdped_ff;
    assign o_rpt_nonfatal = rpt_nf_ff;
    assign o_rpt_fatal    = rpt_fa_ff;

    // Correctable always passes; severe ones need the enable
    always_comb begin
        o_msg_fwd = 1'b0;
        if (i_sec_msg_valid) begin
            unique case (i_sec_msg_kind)
                BPCC_MSG_COR:      o_msg_fwd = 1'b1; // R10
                BPCC_MSG_NONFATAL: o_msg_fwd = cmd.system_error_enable; // R09
                BPCC_MSG_FATAL:    o_msg_fwd = cmd.system_error_enable; // R09
                BPCC_MSG_OTHER:    o_msg_fwd = 1'b1;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupt resolution
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_intx
            assign o_own_intx[g]      = i_own_intx[g] && !cmd.legacy_interrupt_disable; // R11
            // Forwarded lines bypass the disable bit entirely
            assign o_resolved_intx[g] = o_own_intx[g] || i_fwd_intx[g]; // R12
        end
    endgenerate

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    chk_io_claim_gate: assert property ( // R01
        i_pri_io_hit |-> (o_pri_io_claim == cmd_value[BPCC_IO_SPACE_ENABLE_BIT]))
        else $error("io claim does not follow enable");

    chk_mem_claim_gate: assert property ( // R02
        (i_pri_mem_hit || i_pri_pref_hit) && !cmd_value[BPCC_MEMORY_SPACE_ENABLE_BIT]
        |-> !o_pri_mem_claim)
        else $error("memory window claimed while disabled");

    chk_req_block_off: assert property ( // R03
        i_sec_req_valid && bpcc_gated_kind(i_sec_req_kind)
        && !cmd_value[BPCC_REQUEST_FORWARDING_ENABLE_BIT] |-> !o_sec_req_fwd)
        else $error("request forwarded while forwarding off");

    chk_ur_on_block: assert property ( // R04
        i_sec_req_valid && i_sec_req_np && bpcc_gated_kind(i_sec_req_kind)
        && !cmd_value[BPCC_REQUEST_FORWARDING_ENABLE_BIT] |-> o_sec_ur_cpl)
        else $error("missing unsupported request completion");

    chk_cpl_always_pass: assert property ( // R05
        i_sec_req_valid && !bpcc_gated_kind(i_sec_req_kind)
        |-> o_sec_req_fwd && !o_sec_ur_cpl)
        else $error("ungated traffic was blocked");

    chk_poison_sets: assert property ( // R06
        cmd_value[BPCC_PARITY_ERROR_RESPONSE_BIT] && (i_poison_cpl_rx || i_poison_wr_gen)
        |=> o_mdped_set)
        else $error("parity status not set on poison");

    chk_poison_quiet: assert property ( // R07
        $past(!cmd_value[BPCC_PARITY_ERROR_RESPONSE_BIT]) |-> !o_mdped_set)
        else $error("parity status set while response off");

    chk_err_report: assert property ( // R08
        i_own_err_fatal && (cmd_value[BPCC_SYSTEM_ERROR_ENABLE_BIT] || i_devctl_fatal_en)
        ##1 1'b1 |-> o_rpt_fatal)
        else $error("fatal error not reported");

    chk_severe_msg: assert property ( // R09
        i_sec_msg_valid && (i_sec_msg_kind == BPCC_MSG_FATAL
        || i_sec_msg_kind == BPCC_MSG_NONFATAL)
        |-> (o_msg_fwd == cmd_value[BPCC_SYSTEM_ERROR_ENABLE_BIT]))
        else $error("severe message forwarding wrong");

    chk_cor_msg: assert property ( // R10
        i_sec_msg_valid && (i_sec_msg_kind == BPCC_MSG_COR) |-> o_msg_fwd)
        else $error("correctable message dropped");

    chk_own_intx_off: assert property ( // R11
        cmd_value[BPCC_LEGACY_INTERRUPT_DISABLE_BIT] |-> (o_own_intx == 4'h0))
        else $error("own interrupt asserted while disabled");

    chk_fwd_intx_pass: assert property ( // R12
        ((o_resolved_intx & i_fwd_intx) == i_fwd_intx))
        else $error("forwarded interrupt masked");

    chk_ro_zero: assert property ( // R13
        o_cfg_rvalid |-> ((o_cfg_rdata & ~BPCC_PORT_COMMAND_WMASK) == 16'h0000))
        else $error("read-only bits read as nonzero");

endmodule : bpcc_port_cmd

// [verif/bpcc_rc_model.sv]
// Root complex stand-in that tallies error reports arriving from the port
`timescale 1ns/1ps
module bpcc_rc_model (
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    input  wire logic i_rpt_nonfatal,
    input  wire logic i_rpt_fatal,
    input  wire logic i_mdped_set,
    output int        o_err_msgs,
    output int        o_parity_sets
);
    // ------------------------------------------------------------
    // Message tally
    // ------------------------------------------------------------
    // Counts survive reset so a mid-run reset cannot hide lost reports;
    // pulses seen while the port is held in reset are not taken
    always @(posedge i_core_clk) begin
        if (!i_rst) begin
            o_err_msgs    <= o_err_msgs + int'(i_rpt_nonfatal) + int'(i_rpt_fatal);
            o_parity_sets <= o_parity_sets + int'(i_mdped_set);
        end
    end
    initial begin
        o_err_msgs    = 0;
        o_parity_sets = 0;
    end
endmodule : bpcc_rc_model

// [verif/tb_top.sv]
// Self-checking bench for the bridge port command block
`timescale 1ns/1ps
module tb_top;
    import bpcc_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic           clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [11:0]    addr = 12'h000;
    logic [1:0]     be = 2'h0;
    logic [15:0]    wd = 16'h0000, rdata;
    logic           rvalid, hit, ioh = 1'b0, memh = 1'b0, prefh = 1'b0;
    logic           sv = 1'b0, np = 1'b0, pc = 1'b0, pw = 1'b0, onf = 1'b0, ofa = 1'b0;
    logic           dnf = 1'b0, dfa = 1'b0, mv = 1'b0;
    bpcc_req_kind_t kind = BPCC_REQ_MEM;
    bpcc_msg_kind_t mkind = BPCC_MSG_COR;
    logic [3:0]     own = 4'h0, fwi = 4'h0, o_own, o_res;
    logic           ioc, memc, fwd, ur, mdp, rnf, rfa, mfwd;
    int             errors = 0, checked = 0, n_rpt = 0, n_mdp = 0, rc_rpt, rc_mdp;
    integer         seed = 9025;
    // Model state: command now, next command, pending registered results
    logic [15:0]    cmd = 16'h0000, nxt = 16'h0000, p_rd = 16'h0000;
    logic           p_md = 1'b0, p_nf = 1'b0, p_ft = 1'b0, p_rv = 1'b0, p_hit = 1'b0;
    logic           gated;

    always #2 clk = ~clk;

    bpcc_port_cmd i_bpcc_port_cmd (
        .i_core_clk(clk), .i_rst(rst), .i_cfg_wr(wr), .i_cfg_rd(rd),
        .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wd), .o_cfg_rdata(rdata),
        .o_cfg_rvalid(rvalid), .o_cfg_hit(hit), .i_pri_io_hit(ioh),
        .i_pri_mem_hit(memh), .i_pri_pref_hit(prefh), .o_pri_io_claim(ioc),
        .o_pri_mem_claim(memc), .i_sec_req_valid(sv), .i_sec_req_kind(kind),
        .i_sec_req_np(np), .o_sec_req_fwd(fwd), .o_sec_ur_cpl(ur),
        .i_poison_cpl_rx(pc), .i_poison_wr_gen(pw), .o_mdped_set(mdp),
        .i_own_err_nonfatal(onf), .i_own_err_fatal(ofa), .i_devctl_nonfatal_en(dnf),
        .i_devctl_fatal_en(dfa), .o_rpt_nonfatal(rnf), .o_rpt_fatal(rfa),
        .i_sec_msg_valid(mv), .i_sec_msg_kind(mkind), .o_msg_fwd(mfwd),
        .i_own_intx(own), .i_fwd_intx(fwi), .o_own_intx(o_own), .o_resolved_intx(o_res)
    );

    bpcc_rc_model i_bpcc_rc_model (
        .i_core_clk(clk), .i_rst(rst), .i_rpt_nonfatal(rnf), .i_rpt_fatal(rfa),
        .i_mdped_set(mdp), .o_err_msgs(rc_rpt), .o_parity_sets(rc_mdp)
    );

    // ------------------------------------------------------------
    // Compare and verdict
    // ------------------------------------------------------------
    task automatic compare(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (exp !== got) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : compare

    task automatic conclude();
        if (errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    // Watchdog sized well past the 400 stimulus cycles
    initial begin
        #5000;
        errors++;
        conclude();
    end

    // ------------------------------------------------------------
    // Random traffic with a cycle-level reference model
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        for (int c = 0; c < 400; c++) begin
            @(posedge clk);
            cmd = nxt;
            rst <= (c == 200);
            wr <= ($random(seed) & 3) == 0;
            rd <= ($random(seed) & 1) == 0;
            addr <= ($random(seed) & 3) != 0 ? BPCC_PORT_COMMAND_OFS : 12'($random(seed));
            be <= 2'($random(seed));
            wd <= 16'($random(seed));
            {ioh, memh, prefh, sv, np, pc, pw, onf, ofa, dnf, dfa, mv} <= 12'($random(seed));
            kind <= bpcc_req_kind_t'(3'($unsigned($random(seed)) % 5));
            mkind <= bpcc_msg_kind_t'(2'($random(seed)));
            {own, fwi} <= 8'($random(seed));
            #1;
            // Gating answers in the same cycle as the traffic
            gated = sv && kind inside {BPCC_REQ_MEM, BPCC_REQ_IO, BPCC_REQ_MSI};
            compare("io_claim", 16'(ioh & cmd[0]), 16'(ioc));
            compare("mem_claim", 16'((memh | prefh) & cmd[1]), 16'(memc));
            compare("req_fwd", 16'(sv && (cmd[2] || !gated)), 16'(fwd));
            compare("ur_cpl", 16'(gated && np && !cmd[2]), 16'(ur));
            compare("msg_fwd", 16'(mv && (mkind != BPCC_MSG_NONFATAL
                && mkind != BPCC_MSG_FATAL || cmd[8])), 16'(mfwd));
            compare("own_intx", 16'(own & {4{!cmd[10]}}), 16'(o_own));
            compare("resolved_intx", 16'((own & {4{!cmd[10]}}) | fwi), 16'(o_res));
            // Registered answers to the events of the previous cycle
            compare("mdped_set", 16'(p_md), 16'(mdp));
            compare("rpt_err", 16'({p_nf, p_ft}), 16'({rnf, rfa}));
            compare("rd_valid_hit", 16'({p_rv, p_hit}), 16'({rvalid, hit}));
            compare("rd_data", p_rd, rdata);
            // The root complex ignores pulses at an edge that resets the port
            if (!rst) begin
                n_rpt += int'(p_nf) + int'(p_ft);
                n_mdp += int'(p_md);
            end
            // Reset wipes every pending answer and the whole command word
            p_md  = !rst && (pc || pw) && cmd[6];
            p_nf  = !rst && onf && (cmd[8] || dnf);
            p_ft  = !rst && ofa && (cmd[8] || dfa);
            p_rv  = !rst && rd;
            p_hit = p_rv && addr == BPCC_PORT_COMMAND_OFS;
            p_rd  = p_hit ? cmd : 16'h0000;
            nxt   = cmd;
            if (wr && addr == BPCC_PORT_COMMAND_OFS) begin
                if (be[0]) nxt[7:0] = wd[7:0];
                if (be[1]) nxt[15:8] = wd[15:8];
                nxt = nxt & BPCC_PORT_COMMAND_WMASK;
            end
            if (rst) nxt = BPCC_PORT_COMMAND_RST;
        end
        @(posedge clk);
        #1;
        compare("rc_reports", 16'(n_rpt), 16'(rc_rpt));
        compare("rc_parity", 16'(n_mdp), 16'(rc_mdp));
        conclude();
    end
endmodule : tb_top
